// *** bench/sdm_assertions.sv ***
// wire-level checks between the sdram controller and device
`timescale 1ns/10ps
module sdm_assertions
  import sdm_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // link
  input wire logic cke,
  input wire logic csN,
  input wire logic rasN,
  input wire logic casN,
  input wire logic weN,
  input wire logic [1:0] ba,
  input wire logic [12:0] addr,
  input wire logic [1:0] dqm,
  input wire logic dqCtlOeN,
  input wire logic dqMemOeN
);
  logic [3:0] cmd;
  logic hv;
  logic [12:0] hMode;
  logic rd2;
  logic rd3;
  assign cmd = {csN, rasN, casN, weN};
  assign rd2 = cke && cmd == SDM_CMD_READ && hv && hMode[6:4] == CL_CODE_2;
  assign rd3 = cke && cmd == SDM_CMD_READ && hv && hMode[6:4] == CL_CODE_3;
  // shadow of the mode register as seen on the wire
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      hv <= 1'b0;
      hMode <= 13'h0000;
    end
    else if (cke && cmd == SDM_CMD_MRS && ba == BANK_MODE)
    begin
      hv <= 1'b1;
      hMode <= addr;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_cl2_first_beat:
    assert property (rd2 |-> ##2 ($past(dqm, 2) == 2'h3 || !dqMemOeN))
    else $error("no read data two clocks after read");
  a_cl3_first_beat:
    assert property (rd3 |-> ##3 ($past(dqm, 2) == 2'h3 || !dqMemOeN))
    else $error("no read data three clocks after read");
  a_quiet_before_mode:
    assert property (!hv |-> dqMemOeN)
    else $error("device drives data before mode set");
  a_single_beat:
    assert property (rd2 && hMode[2:0] == BL_CODE_1 |-> ##3 dqMemOeN)
    else $error("length one read drives a second beat");
  a_two_beats:
    assert property (rd2 && hMode[2:0] == BL_CODE_2 && dqm == 2'h0 |->
      ##3 ($past(dqm, 2) == 2'h3 || !dqMemOeN) ##1 dqMemOeN)
    else $error("length two read has wrong beat count");
  a_act_after_mode:
    assert property (cke && cmd == SDM_CMD_ACT |-> hv)
    else $error("activate before mode set");
  a_idle_after_mrs:
    assert property (cke && cmd == SDM_CMD_MRS |=>
      cmd == SDM_CMD_NOP || cmd == SDM_CMD_DESEL)
    else $error("command right after mode set");
  a_cke_held:
    assert property (cke)
    else $error("clock enable dropped");
  a_one_driver:
    assert property (dqMemOeN || dqCtlOeN)
    else $error("both ends drive data");
  c_read_cl3: cover property (rd3);
  c_read_ilv: cover property (rd2 && hMode[3]);
  c_refresh: cover property (cke && cmd == SDM_CMD_REF);
endmodule // sdm_assertions

// *** bench/tb_top.sv ***
// testbench: controller and device joined, driven over apb
`timescale 1ns/10ps
module tb_top;
  import sdm_pkg::*;
  localparam int PAUSE = 20;
  // {bad bank mrs, start column, mode}
  localparam logic [22:0] ROWS [8] = '{{1'b0, 9'h005, 13'h0021},
    {1'b0, 9'h007, 13'h003A}, {1'b0, 9'h009, 13'h003B},
    {1'b0, 9'h00A, 13'h0023}, {1'b0, 9'h006, 13'h0032},
    {1'b1, 9'h003, 13'h0029}, {1'b0, 9'h004, 13'h0020},
    {1'b0, 9'h002, 13'h0027}};
  logic mclk, rst, psel, penable, pwrite, pready, pslverr, perr, firstA10;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic modeValid, modeReserved;
  logic [12:0] modeView, md;
  logic [3:0] mc;
  logic [15:0] bDat[$];
  logic [3:0] cLog[$];
  int bCyc[$];
  int cCyc[$];
  int miscompares = 0, testsRun = 0, cyc = 0, rdEdge, k, r, n, bl, st;
  sdm_if lnk ();
  sdm_controller #(.PAUSE_CYCLES(PAUSE)) u_sdm_controller (.mclk(mclk),
    .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(lnk));
  sdm_device u_sdm_device (.mclk(mclk), .rst(rst), .link(lnk),
    .modeValid(modeValid), .modeReserved(modeReserved),
    .modeView(modeView));
  sdm_assertions u_sdm_assertions (.mclk(mclk), .rst(rst), .cke(lnk.cke),
    .csN(lnk.csN), .rasN(lnk.rasN), .casN(lnk.casN), .weN(lnk.weN),
    .ba(lnk.ba), .addr(lnk.addr), .dqm(lnk.dqm),
    .dqCtlOeN(lnk.dqCtlOeN), .dqMemOeN(lnk.dqMemOeN));
  assign mc = {lnk.csN, lnk.rasN, lnk.casN, lnk.weN};
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // logs commands and read beats seen on the link
  always @(posedge mclk)
  begin
    if (!lnk.csN && mc != SDM_CMD_NOP)
    begin
      if (cLog.size() == 0)
        firstA10 = lnk.addr[PRE_ALL_BIT];
      cLog.push_back(mc);
      cCyc.push_back(cyc);
    end
    if (mc == SDM_CMD_READ)
      rdEdge = cyc;
    if (!lnk.dqMemOeN)
    begin
      bCyc.push_back(cyc);
      bDat.push_back(lnk.dq);
    end
    cyc++;
  end
  task automatic final_report(input bit timedOut);
    if (timedOut)
      miscompares++;
    $display("comparisons %0d, mismatches %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d);
    int i;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    for (i = 0; i < 20 && pready !== 1'b1; i++)
      @(posedge mclk);
    if (i == 20)
      final_report(1'b1);
    rdv = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one command through the command register, then wait till it has gone
  task automatic issue(input logic [3:0] c, input logic [1:0] b,
    input logic [12:0] a);
    int i;
    apb(1'b1, REG_CMD, {11'h000, 2'h0, a, b, c});
    for (i = 0; i < 20; i++)
    begin
      apb(1'b0, REG_STATUS, 32'h0);
      if (!rdv[4])
        break;
    end
    if (i == 20)
      final_report(1'b1);
  endtask
  task automatic set_mode(input logic [12:0] m);
    issue(SDM_CMD_PRE, 2'h0, 13'h0400);
    issue(SDM_CMD_MRS, BANK_MODE, m);
    issue(SDM_CMD_ACT, 2'h0, 13'h0000);
  endtask
  function automatic int exp_col(int s, int l, bit il, int i);
    return (s & ~(l - 1)) | (il ? ((s & (l - 1)) ^ i) : ((s + i) & (l - 1)));
  endfunction
  initial
  begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    check({lnk.cke, lnk.dqm, mc}, {3'h7, SDM_CMD_NOP});
    check(modeValid, 1'b0);
    apb(1'b1, REG_MODE, 32'h0020);
    apb(1'b0, REG_MODE, 32'h0);
    check(rdv, 32'h0000_0020);
    check(cLog.size(), 0);
    st = cyc;
    apb(1'b1, REG_CTRL, 32'h1);
    for (k = 0; k < 200; k++)
    begin
      apb(1'b0, REG_STATUS, 32'h0);
      if (rdv[0])
        break;
    end
    check(k < 200, 1'b1);
    check({cLog[0], firstA10}, {SDM_CMD_PRE, 1'b1});
    check(cCyc[0] - st >= PAUSE, 1'b1);
    check(cLog[1], SDM_CMD_MRS);
    for (k = 2; k < 10; k++)
      check(cLog[k], SDM_CMD_REF);
    check(cLog.size(), 10);
    check({modeValid, modeView}, {1'b1, 13'h0020});
    issue(SDM_CMD_ACT, 2'h0, 13'h0000);
    for (k = 0; k < 32; k++)
    begin
      apb(1'b1, REG_DATA, 32'hA000 | k);
      issue(SDM_CMD_WRITE, 2'h0, 13'(k));
    end
    for (r = 0; r < 8; r++)
    begin
      md = ROWS[r][12:0];
      set_mode(md);
      if (ROWS[r][22])
        issue(SDM_CMD_MRS, 2'h1, 13'h0020);
      check({modeView, modeReserved}, {md, 1'b0});
      bl = md[2:0] == BL_CODE_FULL ? 512 : 1 << md[2:0];
      bDat.delete();
      bCyc.delete();
      issue(SDM_CMD_READ, 2'h0, {4'h0, ROWS[r][21:13]});
      if (bl == 512)
        issue(SDM_CMD_BST, 2'h0, 13'h0000);
      repeat (12) @(posedge mclk);
      n = bl > 8 ? bDat.size() : bl;
      check(bDat.size() > 2 || bl < 4, 1'b1);
      check(bDat.size(), n);
      for (k = 0; k < n; k++)
      begin
        check(bCyc[k], rdEdge + md[6:4] + k);
        check(bDat[k], 16'hA000 | exp_col(ROWS[r][21:13], bl, md[3], k));
      end
    end
    set_mode(13'h0222);
    apb(1'b1, REG_DATA, 32'hB000);
    issue(SDM_CMD_WRITE, 2'h0, 13'h0010);
    bDat.delete();
    issue(SDM_CMD_READ, 2'h0, 13'h0010);
    repeat (10) @(posedge mclk);
    check(bDat.size(), 4);
    check({bDat[0], bDat[1]}, 32'hB000A011);
    apb(1'b0, REG_DATA, 32'h0);
    check(rdv, 32'h0000_A013);
    set_mode(13'h0052);
    check(modeReserved, 1'b1);
    set_mode(13'h00A2);
    check(modeReserved, 1'b1);
    apb(1'b0, 12'h0FC, 32'h0);
    check(perr, 1'b1);
    check(rdv, 32'h0);
    // reset again in mid-run: pins idle, mode undefined, init forgotten
    rst <= 1'b1;
    repeat (3) @(posedge mclk);
    check({modeValid, lnk.cke, lnk.dqm, mc}, {4'h7, SDM_CMD_NOP});
    rst <= 1'b0;
    apb(1'b0, REG_STATUS, 32'h0);
    check(rdv, 32'h0);
    final_report(1'b0);
  end
endmodule // tb_top

// *** inc/sdm_if.sv ***
// pin-level link between sdram controller and device
`timescale 1ns/10ps
interface sdm_if;
  logic cke;
  logic csN;
  logic rasN;
  logic casN;
  logic weN;
  logic [1:0] ba;
  logic [12:0] addr;
  logic [1:0] dqm;
  logic [15:0] dqCtl;
  logic dqCtlOeN;
  logic [15:0] dqMem;
  logic dqMemOeN;
  logic [15:0] dq;
  assign dq = !dqMemOeN ? dqMem : (!dqCtlOeN ? dqCtl : 16'h0000);
  modport mem (input cke, csN, rasN, casN, weN, ba, addr, dqm, dq,
    output dqMem, dqMemOeN);
  modport ctl (output cke, csN, rasN, casN, weN, ba, addr, dqm, dqCtl,
    dqCtlOeN, input dq);
endinterface

// *** inc/sdm_pkg.sv ***
// shared constants and types for the sdram init and burst blocks
package sdm_pkg;
  localparam int ROW_W = 13;
  localparam int COL_W = 9;
  localparam int DQ_W = 16;
  // mode register field positions
  localparam int BL_LSB = 0;
  localparam int BL_W = 3;
  localparam int BT_BIT = 3;
  localparam int CL_LSB = 4;
  localparam int CL_W = 3;
  localparam int OPM_LSB = 7;
  localparam int OPM_W = 6;
  localparam logic [2:0] BL_CODE_1 = 3'h0;
  localparam logic [2:0] BL_CODE_2 = 3'h1;
  localparam logic [2:0] BL_CODE_4 = 3'h2;
  localparam logic [2:0] BL_CODE_8 = 3'h3;
  localparam logic [2:0] BL_CODE_FULL = 3'h7;
  localparam logic [2:0] CL_CODE_2 = 3'h2;
  localparam logic [2:0] CL_CODE_3 = 3'h3;
  localparam logic [5:0] OPM_NORMAL = 6'h00;
  localparam logic [5:0] OPM_SINGLE_WR = 6'h04;
  localparam logic [1:0] BANK_MODE = 2'h0;
  localparam int PRE_ALL_BIT = 10;
  // initialisation timing
  localparam int CLK_MHZ = 125;
  localparam int PAUSE_MS = 200;
  localparam longint PAUSE_CYC = longint'(PAUSE_MS) * 1000 * CLK_MHZ;
  localparam int INIT_REFRESHES = 8;
  localparam int MRD_CYC = 2;
  localparam int RFC_CYC = 10;
  localparam int RP_CYC = 3;
  // command code {cs_n, ras_n, cas_n, we_n}
  typedef enum logic [3:0] {
    SDM_CMD_NOP = 4'h7,
    SDM_CMD_DESEL = 4'hF,
    SDM_CMD_ACT = 4'h3,
    SDM_CMD_READ = 4'h5,
    SDM_CMD_WRITE = 4'h4,
    SDM_CMD_PRE = 4'h2,
    SDM_CMD_REF = 4'h1,
    SDM_CMD_MRS = 4'h0,
    SDM_CMD_BST = 4'h6
  } sdm_cmd_t;
  // apb register map of the controller
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_MODE = 12'h004;
  localparam logic [11:0] REG_STATUS = 12'h008;
  localparam logic [11:0] REG_CMD = 12'h00C;
  localparam logic [11:0] REG_DATA = 12'h010;
  localparam int CTRL_START_BIT = 0;
  localparam logic [12:0] MODE_RESET = 13'h0023;
endpackage

// *** rtl/sdm_burst_seq.sv ***
// column sequence generator for one burst
`timescale 1ns/10ps
module sdm_burst_seq
  import sdm_pkg::*;
#(
  parameter int COLS = COL_W
)(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // control
  input wire logic start,
  input wire logic stop,
  input wire logic [COLS-1:0] startCol,
  input wire logic [2:0] lenCode,
  input wire logic interleave,
  // sequence
  output logic active,
  output logic [COLS-1:0] col
);
  if (COLS < 3) $error("column width too small");
  logic [COLS-1:0] base;
  logic [COLS-1:0] cnt;
  logic [COLS-1:0] mask;
  logic [COLS-1:0] lenM1;
  logic full;
  always_comb
  begin
    full = lenCode == BL_CODE_FULL;
    case (lenCode)
      BL_CODE_2: mask = COLS'(1);
      BL_CODE_4: mask = COLS'(3);
      BL_CODE_8: mask = COLS'(7);
      BL_CODE_FULL: mask = '1;
      default: mask = '0;
    endcase
    lenM1 = mask;
  end
  // aligned block fixed, offset wraps inside it
  always_comb
  begin
    if (interleave && !full)
      col = (base & ~mask) | ((base ^ cnt) & mask);
    else
      col = (base & ~mask) | ((base + cnt) & mask);
  end
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      active <= 1'b0;
      base <= '0;
      cnt <= '0;
    end
    else if (start)
    begin
      // the command cycle carries beat 0, so count on from the second beat
      active <= mask != '0;
      base <= startCol;
      cnt <= COLS'(1);
    end
    else if (stop)
      active <= 1'b0;
    else if (active)
    begin
      cnt <= cnt + COLS'(1);
      if (cnt == lenM1 && !full)
        active <= 1'b0;
    end
  end
endmodule // sdm_burst_seq

// *** rtl/sdm_controller.sv ***
// sdram controller: apb registers, power-up sequence, command issue
//
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/10ps
module sdm_controller
  import sdm_pkg::*;
#(
  parameter longint PAUSE_CYCLES = PAUSE_CYC
)(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // link
  sdm_if.ctl link
);
  if (PAUSE_CYCLES < 1) $error("pause must be positive");
  typedef enum {
    ST_RESET, ST_PAUSE, ST_PRE, ST_PRE_W, ST_REF, ST_REF_W, ST_MRS,
    ST_MRS_W, ST_IDLE, ST_CMD, ST_CMD_W
  } sdm_state_t;
  sdm_state_t state;
  logic [31:0] waitCnt;
  logic [3:0] refCnt;
  logic [12:0] modeVal;
  logic startReq;
  logic [31:0] cmdReg;
  logic cmdPend;
  logic [15:0] dataReg;
  logic [15:0] rdCapture;
  logic initDone;
  logic apbWr;
  logic apbAcc;
  assign apbAcc = psel && penable;
  assign apbWr = apbAcc && pwrite;
  assign pready = 1'b1;
  always_comb
  begin
    pslverr = apbAcc && !(paddr == REG_CTRL || paddr == REG_MODE
      || paddr == REG_STATUS || paddr == REG_CMD || paddr == REG_DATA);
  end
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      prdata <= 32'h0000_0000;
    else if (psel && !penable)
    begin
      case (paddr)
        REG_MODE: prdata <= {19'h0, modeVal};
        REG_STATUS: prdata <= {27'h0, cmdPend, refCnt[2:0], initDone};
        REG_CMD: prdata <= cmdReg;
        REG_DATA: prdata <= {16'h0, rdCapture};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end
  // software registers
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      modeVal <= MODE_RESET;
      startReq <= 1'b0;
      cmdReg <= 32'h0000_0000;
      dataReg <= 16'h0000;
    end
    else
    begin
      if (apbWr && paddr == REG_CTRL)
        startReq <= pwdata[CTRL_START_BIT];
      if (apbWr && paddr == REG_MODE)
        modeVal <= pwdata[12:0];
      if (apbWr && paddr == REG_CMD)
        cmdReg <= pwdata;
      if (apbWr && paddr == REG_DATA)
        dataReg <= pwdata[15:0];
    end
  end
  // cmdReg: [3:0] command, [5:4] bank, [18:6] address, [20:19] dqm
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      cmdPend <= 1'b0;
    else if (apbWr && paddr == REG_CMD)
      cmdPend <= 1'b1;
    else if (state == ST_CMD)
      cmdPend <= 1'b0;
  end
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      rdCapture <= 16'h0000;
    else if (!link.dqCtlOeN == 1'b0 && link.dq != 16'h0000)
      rdCapture <= link.dq;
  end
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state <= ST_RESET;
      waitCnt <= 32'h0;
      refCnt <= 4'h0;
      initDone <= 1'b0;
    end
    else
    begin
      case (state)
        ST_RESET:
          if (startReq)
          begin
            state <= ST_PAUSE;
            waitCnt <= 32'(PAUSE_CYCLES - 1);
          end
        ST_PAUSE:
          if (waitCnt == 32'h0)
            state <= ST_PRE;
          else
            waitCnt <= waitCnt - 32'h1;
        ST_PRE:
        begin
          state <= ST_PRE_W;
          waitCnt <= 32'(RP_CYC);
        end
        ST_PRE_W:
          if (waitCnt == 32'h0)
            state <= ST_MRS;
          else
            waitCnt <= waitCnt - 32'h1;
        ST_MRS:
        begin
          state <= ST_MRS_W;
          waitCnt <= 32'(MRD_CYC);
        end
        ST_MRS_W:
          if (waitCnt == 32'h0)
            state <= ST_REF;
          else
            waitCnt <= waitCnt - 32'h1;
        ST_REF:
        begin
          state <= ST_REF_W;
          refCnt <= refCnt + 4'h1;
          waitCnt <= 32'(RFC_CYC);
        end
        ST_REF_W:
          if (waitCnt != 32'h0)
            waitCnt <= waitCnt - 32'h1;
          else if (refCnt == 4'(INIT_REFRESHES))
          begin
            state <= ST_IDLE;
            initDone <= 1'b1;
          end
          else
            state <= ST_REF;
        ST_IDLE:
          if (cmdPend)
            state <= ST_CMD;
        ST_CMD:
        begin
          state <= ST_CMD_W;
          waitCnt <= 32'(MRD_CYC);
        end
        ST_CMD_W:
          if (waitCnt == 32'h0)
            state <= ST_IDLE;
          else
            waitCnt <= waitCnt - 32'h1;
        default:
          state <= ST_RESET;
      endcase
    end
  end
  // pin drive from registers
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      {link.csN, link.rasN, link.casN, link.weN} <= SDM_CMD_NOP;
      link.cke <= 1'b1;
      link.dqm <= 2'h3;
      link.ba <= 2'h0;
      link.addr <= 13'h0;
      link.dqCtl <= 16'h0000;
      link.dqCtlOeN <= 1'b1;
    end
    else
    begin
      {link.csN, link.rasN, link.casN, link.weN} <= SDM_CMD_NOP;
      link.dqCtlOeN <= 1'b1;
      case (state)
        ST_PRE:
        begin
          {link.csN, link.rasN, link.casN, link.weN} <= SDM_CMD_PRE;
          link.addr <= 13'(1) << PRE_ALL_BIT;
        end
        ST_MRS:
        begin
          {link.csN, link.rasN, link.casN, link.weN} <= SDM_CMD_MRS;
          link.ba <= BANK_MODE;
          link.addr <= modeVal;
        end
        ST_REF:
          {link.csN, link.rasN, link.casN, link.weN} <= SDM_CMD_REF;
        ST_CMD:
        begin
          {link.csN, link.rasN, link.casN, link.weN} <= cmdReg[3:0];
          link.ba <= cmdReg[5:4];
          link.addr <= cmdReg[18:6];
          link.dqm <= cmdReg[20:19];
          link.dqCtl <= dataReg;
          link.dqCtlOeN <= cmdReg[3:0] != SDM_CMD_WRITE;
        end
        default:
          link.dqm <= initDone ? 2'h0 : 2'h3;
      endcase
    end
  end
endmodule // sdm_controller

// *** rtl/sdm_device.sv ***
// sdram device model: mode register, burst and data storage
`timescale 1ns/10ps
// Notes on behaviour
// - mode register undefined until first programmed
// - controller holds nop and starts clock
// - controller waits 200 ms, precharges all
// - dqm and cke high during pause
// - mode register set after precharge
// - eight auto refreshes during initialisation
// - mode set precedes any activate
// - banks idle, cke high before set
// - nop right after mode set
// - all command lines low, bank zero loads
// - mode register rewritable any time
// - length code gives 1,2,4,8 locations
// - lengths 2,4,8 in both orders
// - bit 3 selects order
// - burst wraps inside aligned block
// - read data at edge n plus latency
// - bits 12..7 zero mean normal mode
// - bit 9 alone: single-location writes
// - controller avoids reserved encodings; this controller sends any mode value unchecked
// - controller waits mode-register delay
// - full page sequential, runs until stopped
module sdm_device
  import sdm_pkg::*;
#(
  parameter int DEPTH_W = 10
)(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // link
  sdm_if.mem link,
  // status
  output logic modeValid,
  output logic modeReserved,
  output logic [12:0] modeView
);
  if (DEPTH_W < COL_W) $error("depth below column width");
  logic [DQ_W-1:0] mem [0:(1<<DEPTH_W)-1];
  logic [12:0] modeReg;
  logic [ROW_W-1:0] openRow [0:3];
  logic cmdEn;
  logic [3:0] cmd;
  logic [1:0] burstBank;
  logic isWrite;
  logic seqActive;
  logic [COL_W-1:0] seqCol;
  logic startBurst;
  logic stopBurst;
  logic [2:0] lenCode;
  logic [2:0] clCode;
  logic [DEPTH_W-1:0] cellAddr;
  logic [DQ_W-1:0] rdPipe [0:2];
  logic [2:0] vPipe;
  logic [1:0] dqmD1;
  logic [1:0] dqmD2;
  assign cmdEn = link.cke;
  assign cmd = {link.csN, link.rasN, link.casN, link.weN};
  assign startBurst = cmdEn && modeValid
    && (cmd == SDM_CMD_READ || cmd == SDM_CMD_WRITE);
  assign stopBurst = cmdEn && (cmd == SDM_CMD_BST || cmd == SDM_CMD_PRE);
  assign clCode = modeReg[CL_LSB +: CL_W];
  // single-location writes when write-burst option selected
  always_comb
  begin
    lenCode = modeReg[BL_LSB +: BL_W];
    if (modeReg[OPM_LSB +: OPM_W] == OPM_SINGLE_WR && !link.weN
        && cmd == SDM_CMD_WRITE)
      lenCode = BL_CODE_1;
    if (lenCode == BL_CODE_FULL && modeReg[BT_BIT])
      lenCode = BL_CODE_1;
  end
  always_comb
  begin
    modeReserved = !(modeReg[OPM_LSB +: OPM_W] == OPM_NORMAL
      || modeReg[OPM_LSB +: OPM_W] == OPM_SINGLE_WR)
      || !(clCode == CL_CODE_2 || clCode == CL_CODE_3);
  end
  assign modeView = modeReg;
  // mode register: no defined content until first load
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      modeReg <= MODE_RESET;
      modeValid <= 1'b0;
    end
    else if (cmdEn && cmd == SDM_CMD_MRS && link.ba == BANK_MODE)
    begin
      modeReg <= link.addr;
      modeValid <= 1'b1;
    end
  end
  always_ff @(posedge mclk)
  begin
    if (cmdEn && cmd == SDM_CMD_ACT)
      openRow[link.ba] <= link.addr;
  end
  logic [2:0] lenLatched;
  logic btLatched;
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      burstBank <= 2'h0;
      isWrite <= 1'b0;
      lenLatched <= BL_CODE_1;
      btLatched <= 1'b0;
    end
    else if (startBurst)
    begin
      burstBank <= link.ba;
      isWrite <= !link.weN;
      lenLatched <= lenCode;
      btLatched <= modeReg[BT_BIT];
    end
  end
  // length and order taken from the command cycle
  sdm_burst_seq #(.COLS(COL_W)) u_seq (
    .mclk(mclk),
    .rst(rst),
    .start(startBurst),
    .stop(stopBurst),
    .startCol(link.addr[COL_W-1:0]),
    .lenCode(startBurst ? lenCode : lenLatched),
    .interleave(startBurst ? modeReg[BT_BIT] : btLatched),
    .active(seqActive),
    .col(seqCol)
  );
  logic [DEPTH_W-1:0] hashRow;
  assign hashRow = DEPTH_W'({openRow[burstBank], burstBank} << COL_W);
  assign cellAddr = hashRow ^ DEPTH_W'(seqCol);
  logic nowWrite;
  logic nowRead;
  assign nowWrite = startBurst ? !link.weN : (seqActive && isWrite);
  assign nowRead = startBurst ? link.weN : (seqActive && !isWrite);
  logic [DEPTH_W-1:0] accAddr;
  assign accAddr = startBurst
    ? (DEPTH_W'({openRow[link.ba], link.ba} << COL_W)
      ^ DEPTH_W'(link.addr[COL_W-1:0]))
    : cellAddr;
  // byte masks act at once on writes
  always_ff @(posedge mclk)
  begin
    if (nowWrite && cmdEn && !stopBurst)
    begin
      if (!link.dqm[0])
        mem[accAddr][7:0] <= link.dq[7:0];
      if (!link.dqm[1])
        mem[accAddr][15:8] <= link.dq[15:8];
    end
  end
  // read pipe: data driven after edge n, seen at edge n plus latency
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      vPipe <= 3'h0;
      dqmD1 <= 2'h3;
      dqmD2 <= 2'h3;
    end
    else
    begin
      vPipe <= {vPipe[1:0], nowRead && cmdEn && !stopBurst};
      dqmD1 <= link.dqm;
      dqmD2 <= dqmD1;
    end
  end
  always_ff @(posedge mclk)
  begin
    rdPipe[0] <= mem[accAddr];
    rdPipe[1] <= rdPipe[0];
    rdPipe[2] <= rdPipe[1];
  end
  logic outV;
  logic [DQ_W-1:0] outD;
  always_comb
  begin
    if (clCode == CL_CODE_3)
    begin
      outV = vPipe[1];
      outD = rdPipe[1];
    end
    else
    begin
      outV = vPipe[0];
      outD = rdPipe[0];
    end
  end
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      link.dqMem <= 16'h0000;
      link.dqMemOeN <= 1'b1;
    end
    else
    begin
      link.dqMem <= outD;
      link.dqMemOeN <= !(outV && dqmD1 != 2'h3);
    end
  end
endmodule // sdm_device
